/* rtl/elg_pkg.sv */
package elg_pkg;
   // ==========================================
   // Register field codes
   localparam logic [2:0] REG_A      = 3'h7;
   localparam logic [2:0] REG_B      = 3'h0;
   localparam logic [2:0] REG_C      = 3'h1;
   localparam logic [2:0] REG_D      = 3'h2;
   localparam logic [2:0] REG_E      = 3'h3;
   localparam logic [2:0] REG_H      = 3'h4;
   localparam logic [2:0] REG_L      = 3'h5;
   localparam logic [2:0] REG_MEM    = 3'h6;
   // ==========================================
   // Opcode fields
   localparam logic [7:0] PFX_FIRST  = 8'hDD;
   localparam logic [7:0] PFX_SECOND = 8'hFD;
   localparam logic [7:0] OP_ST_IMM  = 8'h36;
   localparam logic [7:0] OP_HALT    = 8'h76;
   localparam logic [1:0] GRP_IMM    = 2'h0;
   localparam logic [1:0] GRP_MOVE   = 2'h1;
   localparam logic [2:0] LOW_IMM    = 3'h6;
   // ==========================================
   // Machine cycle lengths in clocks
   localparam logic [2:0] T_FETCH    = 3'h4;
   localparam logic [2:0] T_MEM      = 3'h3;
   localparam logic [2:0] T_ADDCALC  = 3'h5;
   // ==========================================
   // Reset values
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_WORD  = 16'h0000;

   typedef enum logic [1:0] {
      ELG_IDX_NONE,
      ELG_IDX_FIRST,
      ELG_IDX_SECOND
   } elg_idx_t;
endpackage

/* rtl/elg_regs_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Register file access bundle
interface elg_regs_if;
   logic [2:0] rd_sel;
   logic [7:0] rd_data;
   logic       wr_en;
   logic [2:0] wr_sel;
   logic [7:0] wr_data;
   logic [7:0] reg_h;
   logic [7:0] reg_l;
   modport core (output rd_sel, input rd_data, output wr_en, output wr_sel, output wr_data,
                 input reg_h, input reg_l);
   modport file (input rd_sel, output rd_data, input wr_en, input wr_sel, input wr_data,
                 output reg_h, output reg_l);
endinterface
`default_nettype wire

/* rtl/elg_regfile.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Eight-bit general register file
module elg_regfile (
   input  wire logic clk_i,
   input  wire logic rst_i,
   elg_regs_if.file  rf
);
   logic [7:0] regs_r   [0:7];
   logic [7:0] regs_nxt [0:7];
   logic [7:0] rd_r;
   logic [7:0] rd_nxt;

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         regs_nxt[i] = regs_r[i];
      end
      if (rf.wr_en && rf.wr_sel != elg_pkg::REG_MEM) begin
         regs_nxt[rf.wr_sel] = rf.wr_data;
      end
      rd_nxt = regs_r[rf.rd_sel];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 8; i++) begin
            regs_r[i] <= elg_pkg::RST_BYTE;
         end
         rd_r <= elg_pkg::RST_BYTE;
      end else begin
         for (int i = 0; i < 8; i++) begin
            regs_r[i] <= regs_nxt[i];
         end
         rd_r <= rd_nxt;
      end
   end

   assign rf.rd_data = rd_r;
   assign rf.reg_h   = regs_r[elg_pkg::REG_H];
   assign rf.reg_l   = regs_r[elg_pkg::REG_L];
endmodule
`default_nettype wire

/* rtl/elg_core.sv */
// What this block does
// - Register field: A=111, B..L = 000..101
// - Register copy leaves source unchanged
// - Immediate register load: 7 clocks (4,3)
// - Pointer pair read into register, two cycles
// - DD prefix: first index plus displacement read
// - FD prefix: second index, same 19 clocks
// - Pointer pair store: 7 clocks (4,3)
// - DD prefix indexed store, 19 clocks
// - FD prefix indexed store, five cycles
// - Opcode 36 stores immediate at pointer pair
// - No load changes any status flag
// - Immediate store via pair: 10 clocks (4,3,3)
`timescale 1ns/1ps
`default_nettype none
module elg_core #(
   parameter logic [15:0] RESET_PC = 16'h0000
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  mem_rdata_i,
   input  wire logic [7:0]  flags_i,
   input  wire logic [15:0] first_index_register_i,
   input  wire logic [15:0] second_index_register_i,
   output var  logic [15:0] mem_addr_o,
   output var  logic        mem_rd_o,
   output var  logic        mem_wr_o,
   output var  logic [7:0]  mem_wdata_o,
   output var  logic [7:0]  flags_o,
   output var  logic [7:0]  reg_a_o,
   output var  logic        insn_done_o,
   output var  logic        illegal_o
);
   // ==========================================
   // Machine cycle kinds
   typedef enum {
      ELG_FETCH,
      ELG_ARG,
      ELG_DISP,
      ELG_CALC,
      ELG_READ,
      ELG_WRITE
   } elg_state_t;

   elg_state_t          st_r,      st_nxt;
   logic [2:0]          tcnt_r,    tcnt_nxt;
   logic [15:0]         pc_r,      pc_nxt;
   logic [7:0]          op_r,      op_nxt;
   logic [7:0]          imm_r,     imm_nxt;
   logic [15:0]         ea_r,      ea_nxt;
   elg_pkg::elg_idx_t   idx_r,     idx_nxt;
   logic [15:0]         addr_r,    addr_nxt;
   logic                rd_r,      rd_nxt;
   logic                wr_r,      wr_nxt;
   logic [7:0]          wdata_r,   wdata_nxt;
   logic                done_r,    done_nxt;
   logic                ill_r,     ill_nxt;
   logic [7:0]          flags_r;
   logic [7:0]          a_r,       a_nxt;
   logic [2:0]          tlen;
   logic                last_t;
   logic [7:0]          byte_in;

   elg_regs_if rf ();

   elg_regfile u_regfile (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .rf    (rf)
   );

   // ==========================================
   // Helpers
   function automatic logic [15:0] idx_addr(input logic [15:0] base, input logic [7:0] disp);
      idx_addr = base + {{8{disp[7]}}, disp};
   endfunction

   function automatic logic [2:0] cycle_len(input elg_state_t s);
      case (s)
         ELG_FETCH: cycle_len = elg_pkg::T_FETCH;
         ELG_CALC:  cycle_len = elg_pkg::T_ADDCALC;
         default:   cycle_len = elg_pkg::T_MEM;
      endcase
   endfunction

   assign tlen    = cycle_len(st_r);
   assign last_t  = (tcnt_r == tlen - 3'h1);
   assign byte_in = mem_rdata_i;

   // ==========================================
   // Sequencer
   always_comb begin
      st_nxt     = st_r;
      tcnt_nxt   = last_t ? 3'h0 : tcnt_r + 3'h1;
      pc_nxt     = pc_r;
      op_nxt     = op_r;
      imm_nxt    = imm_r;
      ea_nxt     = ea_r;
      idx_nxt    = idx_r;
      addr_nxt   = addr_r;
      rd_nxt     = 1'b0;
      wr_nxt     = 1'b0;
      wdata_nxt  = wdata_r;
      done_nxt   = 1'b0;
      ill_nxt    = 1'b0;
      rf.rd_sel  = op_r[2:0];
      rf.wr_en   = 1'b0;
      rf.wr_sel  = op_r[5:3];
      rf.wr_data = byte_in;
      a_nxt      = a_r;
      case (st_r)
         ELG_FETCH: begin
            addr_nxt  = pc_r;
            rd_nxt    = !last_t;
            rf.rd_sel = byte_in[2:0];
            if (last_t) begin
               pc_nxt   = pc_r + 16'h0001;
               tcnt_nxt = 3'h0;
               if (byte_in == elg_pkg::PFX_FIRST) begin
                  idx_nxt = elg_pkg::ELG_IDX_FIRST;
               end else if (byte_in == elg_pkg::PFX_SECOND) begin
                  idx_nxt = elg_pkg::ELG_IDX_SECOND;
               end else begin
                  op_nxt = byte_in;
                  if (byte_in == elg_pkg::OP_HALT) begin
                     ill_nxt  = 1'b1;
                     done_nxt = 1'b1;
                     idx_nxt  = elg_pkg::ELG_IDX_NONE;
                  end else if (byte_in[7:6] == elg_pkg::GRP_MOVE) begin
                     if (byte_in[2:0] == elg_pkg::REG_MEM) begin
                        st_nxt   = (idx_r != elg_pkg::ELG_IDX_NONE) ? ELG_DISP : ELG_READ;
                        ea_nxt   = {rf.reg_h, rf.reg_l};
                        addr_nxt = {rf.reg_h, rf.reg_l};
                     end else if (byte_in[5:3] == elg_pkg::REG_MEM) begin
                        st_nxt   = (idx_r != elg_pkg::ELG_IDX_NONE) ? ELG_DISP : ELG_WRITE;
                        ea_nxt   = {rf.reg_h, rf.reg_l};
                        addr_nxt = {rf.reg_h, rf.reg_l};
                        rf.rd_sel = byte_in[2:0];
                     end else begin
                        rf.wr_en   = 1'b1;
                        rf.wr_sel  = byte_in[5:3];
                        rf.wr_data = rf.rd_data;
                        done_nxt   = 1'b1;
                        idx_nxt    = elg_pkg::ELG_IDX_NONE;
                     end
                  end else if (byte_in[7:6] == elg_pkg::GRP_IMM && byte_in[2:0] == elg_pkg::LOW_IMM) begin
                     st_nxt   = (byte_in == elg_pkg::OP_ST_IMM && idx_r != elg_pkg::ELG_IDX_NONE)
                                ? ELG_DISP : ELG_ARG;
                     ea_nxt   = {rf.reg_h, rf.reg_l};
                     addr_nxt = pc_r + 16'h0001;
                  end else begin
                     ill_nxt  = 1'b1;
                     done_nxt = 1'b1;
                     idx_nxt  = elg_pkg::ELG_IDX_NONE;
                  end
               end
            end
         end
         ELG_DISP: begin
            rd_nxt = !last_t;
            addr_nxt = pc_r;
            if (last_t) begin
               pc_nxt = pc_r + 16'h0001;
               case (idx_r)
                  elg_pkg::ELG_IDX_FIRST: ea_nxt = idx_addr(first_index_register_i, byte_in);
                  default:                ea_nxt = idx_addr(second_index_register_i, byte_in);
               endcase
               st_nxt = (op_r == elg_pkg::OP_ST_IMM) ? ELG_ARG : ELG_CALC;
            end
         end
         ELG_ARG: begin
            rd_nxt   = !last_t;
            addr_nxt = pc_r;
            if (last_t) begin
               pc_nxt  = pc_r + 16'h0001;
               imm_nxt = byte_in;
               if (op_r == elg_pkg::OP_ST_IMM) begin
                  st_nxt    = (idx_r != elg_pkg::ELG_IDX_NONE) ? ELG_CALC : ELG_WRITE;
                  wdata_nxt = byte_in;
                  addr_nxt  = ea_r;
               end else begin
                  rf.wr_en  = 1'b1;
                  rf.wr_sel = op_r[5:3];
                  st_nxt    = ELG_FETCH;
                  done_nxt  = 1'b1;
                  idx_nxt   = elg_pkg::ELG_IDX_NONE;
               end
            end
         end
         ELG_CALC: begin
            addr_nxt = ea_r;
            if (last_t) begin
               st_nxt = (op_r[7:6] == elg_pkg::GRP_MOVE && op_r[2:0] == elg_pkg::REG_MEM) ? ELG_READ : ELG_WRITE;
               if (op_r[7:6] == elg_pkg::GRP_MOVE && op_r[5:3] == elg_pkg::REG_MEM) begin
                  wdata_nxt = rf.rd_data;
               end
            end
         end
         ELG_READ: begin
            addr_nxt = ea_r;
            rd_nxt   = !last_t;
            if (last_t) begin
               rf.wr_en  = 1'b1;
               rf.wr_sel = op_r[5:3];
               st_nxt    = ELG_FETCH;
               done_nxt  = 1'b1;
               idx_nxt   = elg_pkg::ELG_IDX_NONE;
            end
         end
         ELG_WRITE: begin
            addr_nxt = ea_r;
            if (tcnt_r == 3'h0 && op_r != elg_pkg::OP_ST_IMM) begin
               wdata_nxt = rf.rd_data;
            end
            wr_nxt = !last_t;
            if (last_t) begin
               st_nxt   = ELG_FETCH;
               done_nxt = 1'b1;
               idx_nxt  = elg_pkg::ELG_IDX_NONE;
            end
         end
         default: begin
            st_nxt = ELG_FETCH;
         end
      endcase
      if (rf.wr_en && rf.wr_sel == elg_pkg::REG_A) begin
         a_nxt = rf.wr_data;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r    <= ELG_FETCH;
         tcnt_r  <= 3'h0;
         pc_r    <= RESET_PC;
         op_r    <= elg_pkg::RST_BYTE;
         imm_r   <= elg_pkg::RST_BYTE;
         ea_r    <= elg_pkg::RST_WORD;
         idx_r   <= elg_pkg::ELG_IDX_NONE;
         addr_r  <= elg_pkg::RST_WORD;
         rd_r    <= 1'b0;
         wr_r    <= 1'b0;
         wdata_r <= elg_pkg::RST_BYTE;
         done_r  <= 1'b0;
         ill_r   <= 1'b0;
         flags_r <= elg_pkg::RST_BYTE;
         a_r     <= elg_pkg::RST_BYTE;
      end else begin
         st_r    <= st_nxt;
         tcnt_r  <= tcnt_nxt;
         pc_r    <= pc_nxt;
         op_r    <= op_nxt;
         imm_r   <= imm_nxt;
         ea_r    <= ea_nxt;
         idx_r   <= idx_nxt;
         addr_r  <= addr_nxt;
         rd_r    <= rd_nxt;
         wr_r    <= wr_nxt;
         wdata_r <= wdata_nxt;
         done_r  <= done_nxt;
         ill_r   <= ill_nxt;
         flags_r <= flags_i;
         a_r     <= a_nxt;
      end
   end

   // ==========================================
   // Outputs
   assign mem_addr_o  = addr_r;
   assign mem_rd_o    = rd_r;
   assign mem_wr_o    = wr_r;
   assign mem_wdata_o = wdata_r;
   assign flags_o     = flags_r;
   assign reg_a_o     = a_r;
   assign insn_done_o = done_r;
   assign illegal_o   = ill_r;
endmodule
`default_nettype wire

/* verif/elg_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Zero-wait external memory
module elg_mem_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        wr_i,
   input  wire logic [7:0]  wdata_i,
   output var  logic [7:0]  rdata_o
);
   logic [7:0] mem [0:65535];
   assign rdata_o = mem[addr_i];
   always @(posedge clk_i) begin
      if (wr_i) begin
         mem[addr_i] <= wdata_i;
      end
   end
endmodule
`default_nettype wire

/* verif/elg_core_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bus and completion checks
module elg_core_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  flags_i,
   input wire logic [7:0]  flags_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic        mem_rd_o,
   input wire logic        mem_wr_o,
   input wire logic [7:0]  mem_wdata_o,
   input wire logic        insn_done_o,
   input wire logic        illegal_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_wr_tail; mem_wr_o ##1 !mem_wr_o; endsequence
   sequence s_quiet; !insn_done_o [*3]; endsequence
   property p_wr_len; $rose(mem_wr_o) |=> s_wr_tail; endproperty
   property p_wr_hold; mem_wr_o && $past(mem_wr_o) |-> $stable(mem_addr_o) && $stable(mem_wdata_o); endproperty
   property p_rd_hold; mem_rd_o && $past(mem_rd_o) |-> $stable(mem_addr_o); endproperty
   property p_rd_len; $rose(mem_rd_o) |=> ##[0:2] !mem_rd_o; endproperty
   property p_excl; !(mem_rd_o && mem_wr_o); endproperty
   property p_flags; !$past(rst_i) && !$past(rst_i, 2) |-> flags_o == $past(flags_i); endproperty
   property p_ill; illegal_o |-> insn_done_o; endproperty
   property p_gap; insn_done_o |=> s_quiet; endproperty
   a_wr_len: assert property (p_wr_len) else $error("write strobe length wrong");
   a_wr_hold: assert property (p_wr_hold) else $error("write address or data moved");
   a_rd_hold: assert property (p_rd_hold) else $error("read address moved");
   a_rd_len: assert property (p_rd_len) else $error("read strobe too long");
   a_excl: assert property (p_excl) else $error("read and write together");
   a_flags: assert property (p_flags) else $error("flags altered");
   a_ill: assert property (p_ill) else $error("illegal pulse without done");
   a_gap: assert property (p_gap) else $error("done pulses too close");
endmodule
bind elg_core elg_core_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .flags_i(flags_i), .flags_o(flags_o),
   .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
   .insn_done_o(insn_done_o), .illegal_o(illegal_o));
`default_nettype wire

/* verif/test_eight_bit_load_group_exec.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Load group bench
module test_eight_bit_load_group_exec;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  flags_i = 8'hA5;
   logic [15:0] ix = 16'h0008;
   logic [15:0] iy = 16'h7FFE;
   logic [15:0] mem_addr_o;
   logic        mem_rd_o;
   logic        mem_wr_o;
   logic [7:0]  mem_wdata_o;
   logic [7:0]  mem_rdata_i;
   logic [7:0]  flags_o;
   logic [7:0]  reg_a_o;
   logic        insn_done_o;
   logic        illegal_o;
   int          errors = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          dt[$];
   logic [7:0]  av[$];
   logic        il[$];
   always #10 clk_i = ~clk_i;
   elg_core dut (.clk_i(clk_i), .rst_i(rst_i), .mem_rdata_i(mem_rdata_i), .flags_i(flags_i),
      .first_index_register_i(ix), .second_index_register_i(iy), .mem_addr_o(mem_addr_o),
      .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .flags_o(flags_o),
      .reg_a_o(reg_a_o), .insn_done_o(insn_done_o), .illegal_o(illegal_o));
   elg_mem_model mem_u (.clk_i(clk_i), .addr_i(mem_addr_o), .wr_i(mem_wr_o), .wdata_i(mem_wdata_o),
      .rdata_o(mem_rdata_i));
   task conclude;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         errors++;
         conclude();
      end
   end
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task gap(input int i, input int exp);
      chk("clocks", 8'(exp), 8'(dt[i] - dt[i-1]));
   endtask
   task load(input logic [8*13-1:0] s, input int n);
      for (int i = 0; i < 65536; i++) mem_u.mem[i] = 8'h00;
      for (int i = 0; i < n; i++) mem_u.mem[i] = s[8*(n-1-i)+:8];
   endtask
   task go(input int n);
      int k;
      logic p;
      dt.delete();
      av.delete();
      il.delete();
      k = 0;
      p = 1'b0;
      rst_i = 1'b1;
      repeat (8) @(negedge clk_i);
      rst_i = 1'b0;
      while (dt.size() < n && k < 400) begin
         @(negedge clk_i);
         k++;
         if (p) av.push_back(reg_a_o);
         p = (insn_done_o === 1'b1);
         if (p) begin
            dt.push_back(cyc);
            il.push_back(illegal_o);
         end
      end
      @(negedge clk_i);
      if (p) av.push_back(reg_a_o);
      if (k >= 400) errors++;
   endtask
   task t_codes;
      int c;
      load(8'h7F, 1);
      for (int i = 0; i < 7; i++) begin
         c = (i == 6) ? 7 : i;
         mem_u.mem[1+3*i] = {2'b00, c[2:0], 3'b110};
         mem_u.mem[2+3*i] = 8'(8'h11 * (i + 1));
         mem_u.mem[3+3*i] = {5'b01111, c[2:0]};
      end
      mem_u.mem[22] = 8'h70;
      go(16);
      for (int i = 0; i < 7; i++) begin
         chk("reg_a", 8'(8'h11 * (i + 1)), av[2*i+2]);
         gap(2*i+1, 7);
         gap(2*i+2, 4);
      end
      gap(15, 7);
      chk("mem_5566", 8'h11, mem_u.mem[16'h5566]);
      $display("register codes test ended");
   endtask
   task t_ptr;
      load(64'h7F26402E007E3699, 8);
      mem_u.mem[16'h4000] = 8'hC3;
      go(5);
      chk("reg_a", 8'hC3, av[3]);
      gap(3, 7);
      gap(4, 10);
      chk("mem_4000", 8'h99, mem_u.mem[16'h4000]);
      $display("pointer pair test ended");
   endtask
   task t_idx;
      load(104'h7FDD7EF0FD7705FD7E01DD7780, 13);
      mem_u.mem[16'hFFF8] = 8'hA7;
      mem_u.mem[16'h7FFF] = 8'h3C;
      go(5);
      gap(1, 19);
      gap(2, 19);
      gap(3, 19);
      gap(4, 19);
      chk("reg_a", 8'hA7, av[1]);
      chk("reg_a", 8'h3C, av[3]);
      chk("mem_8003", 8'hA7, mem_u.mem[16'h8003]);
      chk("mem_FF88", 8'h3C, mem_u.mem[16'hFF88]);
      $display("indexed test ended");
   endtask
   task t_ill;
      flags_i = 8'h3C;
      load(24'h7F767F, 3);
      go(3);
      chk("illegal", 8'h01, {7'h00, il[1]});
      chk("illegal", 8'h00, {7'h00, il[2]});
      chk("flags", 8'h3C, flags_o);
      $display("illegal and flags test ended");
   endtask
   initial begin
      t_codes();
      t_ptr();
      t_idx();
      t_ill();
      conclude();
   end
endmodule
`default_nettype wire
